// file: wdt_pkg.sv
// Purpose: shared constants for the watchdog timer unit
// Assumes: 8-bit special function register port of the host core
// Notes: interval counts also appear as top-level parameters
package wdt_pkg;

  localparam logic [7:0] WDT_CLOCK_CONTROL_ADDR = 8'h8e;
  localparam logic [7:0] WDT_WATCHDOG_CONTROL_ADDR = 8'hd8;
  localparam logic [7:0] WDT_CLOCK_CONTROL_RESET = 8'h03;
  localparam logic [7:0] WDT_WATCHDOG_CONTROL_RESET = 8'h00;

  localparam int WDT_SEL_HI_BIT = 7;
  localparam int WDT_SEL_LO_BIT = 6;
  localparam int WDT_RESTART_BIT = 0;
  localparam int WDT_RESET_ENABLE_BIT = 1;
  localparam int WDT_RESET_CAUSE_BIT = 2;
  localparam int WDT_IRQ_FLAG_BIT = 3;

  localparam int unsigned WDT_INTERVAL_CLOCKS_0 = 131072;
  localparam int unsigned WDT_INTERVAL_CLOCKS_1 = 1048576;
  localparam int unsigned WDT_INTERVAL_CLOCKS_2 = 8388608;
  localparam int unsigned WDT_INTERVAL_CLOCKS_3 = 67108864;
  localparam int WDT_COUNT_WIDTH = 26;

  localparam int unsigned WDT_RESET_DELAY_CLOCKS = 512;
  localparam int WDT_DELAY_WIDTH = 9;
  localparam int unsigned WDT_SLOW_FACTOR = 256;
  localparam int WDT_SLOW_WIDTH = 8;

  typedef enum logic {
    WDT_DELAY_IDLE = 1'b0,
    WDT_DELAY_ARMED = 1'b1
  } wdt_delay_state_type;

endpackage

// file: wdt_prescaler.sv
// Purpose: clock-rate prescaler for the watchdog interval counter
// Assumes: slow mode input is synchronous to clk
// Notes: tick every clock normally, every 256th clock in slow mode
`timescale 1ns/100ps
module wdt_prescaler
  import wdt_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic slowMode,
  input wire logic clear,
  output logic tick
);

  logic [WDT_SLOW_WIDTH-1:0] slowCount_reg;
  logic [WDT_SLOW_WIDTH-1:0] slowCount_next;
  logic slowWrap;

  assign slowWrap = (slowCount_reg == WDT_SLOW_WIDTH'(WDT_SLOW_FACTOR - 1));
  assign slowCount_next = clear ? '0 : slowCount_reg + 1'b1;
  assign tick = !clear && (!slowMode || slowWrap);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      slowCount_reg <= '0;
    end
    else
    begin
      slowCount_reg <= slowCount_next;
    end
  end

endmodule

// file: wdt_delay_counter.sv
// Purpose: fixed delay between timeout and cpu reset
// Assumes: run held high for the whole delay
// Notes: done is high in the last clock of the delay, combinational
`timescale 1ns/100ps
module wdt_delay_counter
  import wdt_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic run,
  output logic done
);

  logic [WDT_DELAY_WIDTH-1:0] delayCount_reg;
  logic [WDT_DELAY_WIDTH-1:0] delayCount_next;
  logic lastClock;

  assign lastClock = (delayCount_reg == WDT_DELAY_WIDTH'(WDT_RESET_DELAY_CLOCKS - 1));
  assign delayCount_next = run ? delayCount_reg + 1'b1 : '0;
  assign done = run && lastClock;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      delayCount_reg <= '0;
    end
    else
    begin
      delayCount_reg <= delayCount_next;
    end
  end

endmodule

// file: wdt_watchdog_timer_unit.sv
// Purpose: watchdog timer with interval select, interrupt flag and cpu reset
// Assumes: sfr port synchronous to clk; timed-access unlock decided outside
// Notes: reset cause flag survives reset_n, cleared by external pin or by a software write of zero
//
// How it works
// RULE_01 - timeout after 2^17, 2^20, 2^23, 2^26 clocks
// RULE_02 - every expiry sets the interrupt flag
// RULE_03 - interrupt needs flag, enable and global enable
// RULE_04 - cpu reset 512 clocks after flag set
// RULE_05 - restart bit restarts the count
// RULE_06 - restart bit clears itself
// RULE_07 - reset cause flag set on watchdog reset
// RULE_08 - writing reset cause flag causes no reset
// RULE_09 - no reset cause flag while reset disabled
// RULE_10 - software-set interrupt flag interrupts too
// RULE_11 - interrupt flag sticky until software or reset
// RULE_12 - reset enable gates only cpu reset
// RULE_13 - counter free-runs with everything disabled
// RULE_14 - control writes only under timed access; clock control writes need no timed access here
// RULE_15 - slow mode stretches interval by 256
// RULE_16 - interval and delay counted in clk periods
// RULE_17 - interval select in top bits, reset 0x03
// RULE_18 - upper four control bits unimplemented
// RULE_19 - software programs interval, restarts, then enables
// RULE_20 - system reset clears counter and control bits
`timescale 1ns/100ps
module wdt_watchdog_timer_unit
  import wdt_pkg::*;
#(
  parameter int unsigned INTERVAL_CLOCKS_0 = WDT_INTERVAL_CLOCKS_0,
  parameter int unsigned INTERVAL_CLOCKS_1 = WDT_INTERVAL_CLOCKS_1,
  parameter int unsigned INTERVAL_CLOCKS_2 = WDT_INTERVAL_CLOCKS_2,
  parameter int unsigned INTERVAL_CLOCKS_3 = WDT_INTERVAL_CLOCKS_3
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic externalResetPin_n,
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrEn,
  input wire logic [7:0] sfrWrData,
  input wire logic sfrRdEn,
  output logic [7:0] sfrRdData,
  input wire logic timedAccessOpen,
  input wire logic watchdogIrqEnable,
  input wire logic globalIrqEnable,
  input wire logic powerManagedMode,
  output logic watchdogIrqRequest,
  output logic cpuResetRequest,
  output logic [7:0] clockControl
);

  // terminal count of the selected interval
  function automatic logic [WDT_COUNT_WIDTH-1:0] terminalCount(input logic [1:0] sel);
    logic [WDT_COUNT_WIDTH-1:0] result;
    result = '0;
    unique case (sel)
      2'b00: result = WDT_COUNT_WIDTH'(INTERVAL_CLOCKS_0 - 1);
      2'b01: result = WDT_COUNT_WIDTH'(INTERVAL_CLOCKS_1 - 1);
      2'b10: result = WDT_COUNT_WIDTH'(INTERVAL_CLOCKS_2 - 1);
      2'b11: result = WDT_COUNT_WIDTH'(INTERVAL_CLOCKS_3 - 1);
    endcase
    return result;
  endfunction

  logic [7:0] clockControl_reg;
  logic [7:0] clockControl_next;
  logic resetEnable_reg;
  logic resetEnable_next;
  logic irqFlag_reg;
  logic irqFlag_next;
  logic resetCause_reg;
  logic resetCause_next;
  logic restartStrobe_reg;
  logic restartStrobe_next;
  logic [WDT_COUNT_WIDTH-1:0] intervalCount_reg;
  logic [WDT_COUNT_WIDTH-1:0] intervalCount_next;
  wdt_delay_state_type delayState_reg;
  wdt_delay_state_type delayState_next;
  logic irqRequest_reg;
  logic irqRequest_next;
  logic cpuReset_reg;
  logic cpuReset_next;
  logic [7:0] rdData_reg;
  logic [7:0] rdData_next;

  logic clockControlWrite;
  logic watchdogControlWrite;
  logic restartRequest;
  logic prescaleTick;
  logic [1:0] intervalSelect;
  logic [WDT_COUNT_WIDTH-1:0] intervalTerminal;
  logic timeoutHit;
  logic delayRun;
  logic delayDone;
  logic watchdogResetFire;
  logic [7:0] watchdogControlView;
  logic [7:0] readMux;

  // register decode
  assign clockControlWrite = sfrWrEn && (sfrAddr == WDT_CLOCK_CONTROL_ADDR);
  assign watchdogControlWrite = sfrWrEn && timedAccessOpen
                                && (sfrAddr == WDT_WATCHDOG_CONTROL_ADDR); // RULE_14
  assign restartRequest = watchdogControlWrite && sfrWrData[WDT_RESTART_BIT]; // RULE_05

  assign intervalSelect = clockControl_reg[WDT_SEL_HI_BIT:WDT_SEL_LO_BIT]; // RULE_17
  assign intervalTerminal = terminalCount(intervalSelect); // RULE_01

  // counter advance, every clk or every 256th in slow mode
  wdt_prescaler prescaler_inst (
    .clk(clk),
    .reset_n(reset_n),
    .slowMode(powerManagedMode),
    .clear(restartRequest),
    .tick(prescaleTick)
  );

  // free-running interval counter, wraps at the terminal
  assign timeoutHit = prescaleTick && (intervalCount_reg >= intervalTerminal); // RULE_01 RULE_15 RULE_16

  always_comb
  begin
    intervalCount_next = intervalCount_reg;
    if (restartRequest)
    begin
      intervalCount_next = '0; // RULE_05
    end
    else if (timeoutHit)
    begin
      intervalCount_next = '0; // RULE_13
    end
    else if (prescaleTick)
    begin
      intervalCount_next = intervalCount_reg + 1'b1; // RULE_16
    end
  end

  // reset delay, measured in raw clk periods
  assign delayRun = (delayState_reg == WDT_DELAY_ARMED);

  wdt_delay_counter delay_inst (
    .clk(clk),
    .reset_n(reset_n),
    .run(delayRun),
    .done(delayDone)
  );

  always_comb
  begin
    delayState_next = delayState_reg;
    unique case (delayState_reg)
      WDT_DELAY_IDLE:
      begin
        if (timeoutHit && resetEnable_reg && !restartRequest)
        begin
          delayState_next = WDT_DELAY_ARMED; // RULE_04
        end
      end
      WDT_DELAY_ARMED:
      begin
        if (restartRequest || !resetEnable_reg || delayDone)
        begin
          delayState_next = WDT_DELAY_IDLE; // RULE_05 RULE_12
        end
      end
    endcase
  end

  assign watchdogResetFire = delayRun && delayDone && resetEnable_reg
                             && !restartRequest; // RULE_04 RULE_09 RULE_12
  assign cpuReset_next = watchdogResetFire; // RULE_04

  // control and status bits, hardware set wins over software clear
  always_comb
  begin
    resetEnable_next = resetEnable_reg;
    irqFlag_next = irqFlag_reg;
    resetCause_next = resetCause_reg;
    if (watchdogControlWrite)
    begin
      resetEnable_next = sfrWrData[WDT_RESET_ENABLE_BIT];
      irqFlag_next = sfrWrData[WDT_IRQ_FLAG_BIT]; // RULE_10 RULE_11
      resetCause_next = sfrWrData[WDT_RESET_CAUSE_BIT]; // RULE_08
    end
    if (timeoutHit)
    begin
      irqFlag_next = 1'b1; // RULE_02 RULE_13
    end
    if (watchdogResetFire)
    begin
      resetCause_next = 1'b1; // RULE_07
    end
  end

  assign restartStrobe_next = restartRequest; // RULE_06
  assign clockControl_next = clockControlWrite ? sfrWrData : clockControl_reg;

  // interrupt request independent of reset enable
  assign irqRequest_next = irqFlag_next && watchdogIrqEnable
                           && globalIrqEnable; // RULE_03 RULE_10 RULE_11 RULE_12

  // read view, upper four bits read as zero
  assign watchdogControlView = {4'h0, irqFlag_reg, resetCause_reg,
                                resetEnable_reg, restartStrobe_reg}; // RULE_18
  assign readMux = (sfrAddr == WDT_CLOCK_CONTROL_ADDR) ? clockControl_reg :
                   (sfrAddr == WDT_WATCHDOG_CONTROL_ADDR) ? watchdogControlView :
                   8'h00;
  assign rdData_next = sfrRdEn ? readMux : rdData_reg;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      clockControl_reg <= WDT_CLOCK_CONTROL_RESET; // RULE_17
    end
    else
    begin
      clockControl_reg <= clockControl_next;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      resetEnable_reg <= WDT_WATCHDOG_CONTROL_RESET[WDT_RESET_ENABLE_BIT]; // RULE_20
    end
    else
    begin
      resetEnable_reg <= resetEnable_next;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irqFlag_reg <= WDT_WATCHDOG_CONTROL_RESET[WDT_IRQ_FLAG_BIT]; // RULE_11
    end
    else
    begin
      irqFlag_reg <= irqFlag_next;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      restartStrobe_reg <= WDT_WATCHDOG_CONTROL_RESET[WDT_RESTART_BIT];
    end
    else
    begin
      restartStrobe_reg <= restartStrobe_next;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      intervalCount_reg <= '0; // RULE_20
    end
    else
    begin
      intervalCount_reg <= intervalCount_next;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      delayState_reg <= WDT_DELAY_IDLE;
    end
    else
    begin
      delayState_reg <= delayState_next;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irqRequest_reg <= 1'b0;
      cpuReset_reg <= 1'b0;
      rdData_reg <= 8'h00;
    end
    else
    begin
      irqRequest_reg <= irqRequest_next;
      cpuReset_reg <= cpuReset_next;
      rdData_reg <= rdData_next;
    end
  end

  // cause flag must survive the reset it reports
  always_ff @(posedge clk or negedge externalResetPin_n)
  begin
    if (!externalResetPin_n)
    begin
      resetCause_reg <= WDT_WATCHDOG_CONTROL_RESET[WDT_RESET_CAUSE_BIT]; // RULE_07
    end
    else
    begin
      resetCause_reg <= resetCause_next;
    end
  end

  assign sfrRdData = rdData_reg;
  assign watchdogIrqRequest = irqRequest_reg;
  assign cpuResetRequest = cpuReset_reg;
  assign clockControl = clockControl_reg;

endmodule

// file: wdt_monitor.sv
// Purpose: port checker for the watchdog timer unit
// Assumes: INTERVAL_CLOCKS_0 is the shortest interval
// Notes: bound to the top module below
`timescale 1ns/100ps
module wdt_monitor
#(
  parameter int unsigned INTERVAL_CLOCKS_0 = 16
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic externalResetPin_n,
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrEn,
  input wire logic [7:0] sfrWrData,
  input wire logic sfrRdEn,
  input wire logic [7:0] sfrRdData,
  input wire logic timedAccessOpen,
  input wire logic watchdogIrqEnable,
  input wire logic globalIrqEnable,
  input wire logic powerManagedMode,
  input wire logic watchdogIrqRequest,
  input wire logic cpuResetRequest,
  input wire logic [7:0] clockControl
);
  logic acc;
  logic enReg;
  logic [31:0] sinceRestart;
  assign acc = sfrWrEn && timedAccessOpen && sfrAddr == 8'hd8;
  // cycles since the last accepted restart
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      enReg <= 1'b0;
      sinceRestart <= 32'h0000_0000;
    end
    else
    begin
      if (acc)
        enReg <= sfrWrData[1];
      if (acc && sfrWrData[0])
        sinceRestart <= 32'h0000_0000;
      else if (sinceRestart != 32'hffff_ffff)
        sinceRestart <= sinceRestart + 32'h0000_0001;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  irq_gate_a: assert property (watchdogIrqRequest |->
    $past(watchdogIrqEnable) && $past(globalIrqEnable)) else $error("irq without enables");
  irq_fall_a: assert property ($fell(watchdogIrqRequest) |-> $past(acc) ||
    !$past(watchdogIrqEnable) || !$past(globalIrqEnable)) else $error("irq dropped");
  reset_pulse_a: assert property (cpuResetRequest |=> !cpuResetRequest)
    else $error("reset pulse too long");
  reset_delay_a: assert property (cpuResetRequest |->
    sinceRestart >= 512 + INTERVAL_CLOCKS_0) else $error("reset too early");
  reset_enable_a: assert property (cpuResetRequest |-> enReg || $past(enReg))
    else $error("reset while disabled");
  clock_control_init_a: assert property ($rose(reset_n) |-> clockControl == 8'h03)
    else $error("clock control reset value");
  clock_control_write_a: assert property (sfrWrEn && sfrAddr == 8'h8e |=>
    clockControl == $past(sfrWrData)) else $error("clock control write");
  clock_control_read_a: assert property (sfrRdEn && sfrAddr == 8'h8e |=>
    sfrRdData == $past(clockControl)) else $error("clock control read");
  upper_bits_a: assert property (sfrRdEn && sfrAddr == 8'hd8 |=>
    sfrRdData[7:4] == 4'h0) else $error("upper bits not zero");
endmodule
bind wdt_watchdog_timer_unit wdt_monitor #(.INTERVAL_CLOCKS_0(INTERVAL_CLOCKS_0)) mon (
  .clk(clk), .reset_n(reset_n), .externalResetPin_n(externalResetPin_n),
  .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn),
  .sfrRdData(sfrRdData), .timedAccessOpen(timedAccessOpen),
  .watchdogIrqEnable(watchdogIrqEnable), .globalIrqEnable(globalIrqEnable),
  .powerManagedMode(powerManagedMode), .watchdogIrqRequest(watchdogIrqRequest),
  .cpuResetRequest(cpuResetRequest), .clockControl(clockControl));

// file: wdt_cpu_model.sv
// Purpose: core reset and interrupt logic beside the watchdog
// Assumes: a watchdog reset pulls system reset for two clocks
// Notes: counts reset pulses and interrupt requests
`timescale 1ns/100ps
module wdt_cpu_model
(
  input wire logic clk,
  input wire logic cpuResetRequest,
  input wire logic watchdogIrqRequest,
  output logic coreReset_n,
  output int resetCount,
  output int irqCount
);
  logic prevIrq = 1'b0;
  int holdLeft = 0;
  int resetTally = 0;
  int irqTally = 0;
  assign resetCount = resetTally;
  assign irqCount = irqTally;
  assign coreReset_n = (holdLeft == 0);
  always @(posedge clk)
  begin
    if (cpuResetRequest)
    begin
      resetTally <= resetTally + 1;
      holdLeft <= 2;
    end
    else if (holdLeft > 0)
      holdLeft <= holdLeft - 1;
    if (watchdogIrqRequest && !prevIrq)
      irqTally <= irqTally + 1;
    prevIrq <= watchdogIrqRequest;
  end
endmodule

// file: wdt_watchdog_timer_unit_tb_top.sv
// Purpose: self-checking bench for the watchdog timer unit
// Assumes: intervals shortened to 16, 32, 64, 128 clocks
// Notes: the core model pulls system reset on a watchdog reset
`timescale 1ns/100ps
module wdt_watchdog_timer_unit_tb_top;
  localparam int IVL[4] = '{16, 32, 64, 128};
  logic clk = 1'b0, external_reset_pin = 1'b0, extN = 1'b0;
  logic wr = 1'b0, rd = 1'b0, ta = 1'b0, ien = 1'b0, gen = 1'b0, power_managed_mode = 1'b0;
  logic [7:0] addr = 8'h00, wd = 8'h00, rdData, ckc, v;
  logic irq, cpuRst, coreN;
  int resets, irqs, n, k;
  int badCount = 0, nCompared = 0;
  logic [31:0] seed = 32'h7c5e_1f74;
  always #10 clk = ~clk;
  wdt_watchdog_timer_unit #(.INTERVAL_CLOCKS_0(16), .INTERVAL_CLOCKS_1(32),
    .INTERVAL_CLOCKS_2(64), .INTERVAL_CLOCKS_3(128)) DUT (
    .clk(clk), .reset_n(external_reset_pin & coreN), .externalResetPin_n(extN), .sfrAddr(addr),
    .sfrWrEn(wr), .sfrWrData(wd), .sfrRdEn(rd), .sfrRdData(rdData), .timedAccessOpen(ta),
    .watchdogIrqEnable(ien), .globalIrqEnable(gen), .powerManagedMode(power_managed_mode),
    .watchdogIrqRequest(irq), .cpuResetRequest(cpuRst), .clockControl(ckc));
  wdt_cpu_model core (.clk(clk), .cpuResetRequest(cpuRst), .watchdogIrqRequest(irq),
    .coreReset_n(coreN), .resetCount(resets), .irqCount(irqs));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic int expIvl(input int c, input bit slow);
    return IVL[c] * (slow ? 256 : 1);
  endfunction
  task automatic testDone();
    $display("compared %0d mismatches %0d", nCompared, badCount);
    if (badCount == 0 && nCompared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp)
    begin
      badCount++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wrReg(input logic [7:0] a, input logic [7:0] d, input logic t);
    @(posedge clk);
    addr <= a;
    wd <= d;
    ta <= t;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    ta <= 1'b0;
  endtask
  task automatic rdReg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdData;
  endtask
  task automatic waitSig(input bit sel, input int lim);
    n = 0;
    #1;
    while ((sel ? cpuRst : irq) !== 1'b1 && n < lim)
    begin
      cyc(1);
      n++;
    end
    if (n >= lim)
    begin
      badCount++;
      $display("MISMATCH %0t wait ran out", $time);
      testDone();
    end
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    external_reset_pin <= 1'b1;
    extN <= 1'b1;
    rdReg(8'h8e);
    check(v, 8'h03);
    rdReg(8'hd8);
    check(v, 8'h00);
    seed = xs(seed);
    rdReg({2'b00, seed[5:0]});
    check(v, 8'h00);
    ien <= 1'b1;
    gen <= 1'b1;
    for (int c = 0; c < 4; c++)
    begin
      seed = xs(seed);
      wrReg(8'h8e, {2'(c), seed[5:0]}, 1'b0);
      wrReg(8'hd8, 8'h01, 1'b1);
      waitSig(0, 1000);
      check(n >= expIvl(c, 0) && n <= expIvl(c, 0) + 2, 1);
      cyc(3);
      check(irq, 1);
      wrReg(8'hd8, 8'h00, 1'b1);
      cyc(1);
      check(irq, 0);
    end
    wrReg(8'hd8, 8'h01, 1'b1);
    for (int g = 0; g < 4; g++)
    begin
      ien <= g[0];
      gen <= g[1];
      wrReg(8'hd8, 8'h08, 1'b0);
      cyc(1);
      check(irq, 0);
      k = irqs;
      wrReg(8'hd8, 8'h08, 1'b1);
      cyc(1);
      check(irq, g == 3);
      check(irqs - k, g == 3);
      wrReg(8'hd8, 8'h00, 1'b1);
    end
    ien <= 1'b0;
    gen <= 1'b0;
    wrReg(8'h8e, 8'h03, 1'b0);
    wrReg(8'hd8, 8'h01, 1'b1);
    rdReg(8'hd8);
    check(v, 8'h00);
    cyc(40);
    rdReg(8'hd8);
    check(v, 8'h08);
    wrReg(8'hd8, 8'h00, 1'b1);
    cyc(20);
    rdReg(8'hd8);
    check(v, 8'h08);
    check(resets, 0);
    ien <= 1'b1;
    gen <= 1'b1;
    wrReg(8'hd8, 8'h01, 1'b1);
    wrReg(8'hd8, 8'h02, 1'b1);
    repeat (20)
    begin
      seed = xs(seed);
      cyc(seed[2:0]);
      wrReg(8'hd8, 8'h03, 1'b1);
    end
    check(resets, 0);
    waitSig(0, 100);
    waitSig(1, 600);
    check(n, 512);
    cyc(4);
    rdReg(8'hd8);
    check(v[2:0], 3'b100);
    check(resets, 1);
    wrReg(8'hd8, 8'h00, 1'b1);
    rdReg(8'hd8);
    check(v[2], 0);
    wrReg(8'hd8, 8'h04, 1'b1);
    cyc(5);
    rdReg(8'hd8);
    check(v[2], 1);
    check(resets, 1);
    @(posedge clk);
    extN <= 1'b0;
    @(posedge clk);
    extN <= 1'b1;
    rdReg(8'hd8);
    check(v[2], 0);
    @(posedge clk);
    power_managed_mode <= 1'b1;
    wrReg(8'hd8, 8'h01, 1'b1);
    waitSig(0, 5000);
    check(n > expIvl(0, 1) - 256 && n <= expIvl(0, 1) + 256, 1);
    testDone();
  end
endmodule
